// ===== rtl/sar_adc_sequencer.v
// sequencer, result buffer and wishbone slave of the 10-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_sequencer_regs.vh"

// What this block does
// - sixteen inputs feed four sample-and-hold channels, one 10-bit converter
// - sixteen 10-bit result words, readable by software, never writable
// - setting sample control starts acquisition; chosen trigger starts conversion
// - each result is stored; flag and done set after programmed sequences
// - simultaneous select 0 samples in turn; 1 samples together, converts in turn
// - channel count picks channel 0, channels 0-1, or channels 0-3
// - sequences per interrupt field selects one to sixteen sequences
// - split mode uses two eight-word halves, swapped at each interrupt
// - alternate select toggles mux A and mux B on successive sequences
// - scan steps channel 0 over mask inputs, lowest first, restart at interrupt
// - three-bit trigger field picks software, auto, timer, pwm or external
// - software trigger: clearing sample control starts the conversion
// - auto trigger: convert after auto-sample clocks of acquisition
// - auto trigger with count one gives thirteen clock periods per sample
// - non-auto triggers add synchronising clock periods before converting
// - clearing converter on aborts conversion, buffer keeps last result
// - clearing converter on beats a coincident automatic start
// - after abort, sequencing resumes at next channel; simultaneous mode restarts the group at channel 0
// - conversion takes twelve periods; period is half cycle times divider+1
// - buffer reads apply one of four output formats
module sar_adc_sequencer (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire [2:0]  trig_i,
    input  wire [9:0]  adc_result_i,
    output reg  [3:0]  ch0_input_o,
    output reg         mux_b_o,
    output reg  [3:0]  sample_hold_o,
    output reg         conv_busy_o,
    output reg  [1:0]  conv_chan_o,
    output reg         irq_o
);

    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_SAMPLE_CTRL = 4'b0010;
    localparam [3:0] S_SYNC = 4'b0100;
    localparam [3:0] S_CONV = 4'b1000;

    // configuration and status
    reg        converter_on_q;
    reg [1:0]  output_format_sel_q;
    reg [2:0]  trigger_source_sel_q;
    reg        simultaneous_sample_sel_q;
    reg        sample_ctrl_q;
    reg        done_q;
    reg        ch0_scan_enable_q;
    reg [1:0]  channel_count_sel_q;
    reg [3:0]  seq_per_irq_q;
    reg        buffer_split_mode_q;
    reg        alternate_mux_sel_q;
    reg [4:0]  auto_sample_clocks_q;
    reg [5:0]  conv_clock_divider_q;
    reg [3:0]  ch0_a_q;
    reg [3:0]  ch0_b_q;
    reg [15:0] scan_input_mask_q;
    reg        conv_irq_flag_q;

    // sequencer state
    reg [3:0]  state_q;
    reg [5:0]  tad_cnt_q;
    reg [4:0]  ph_q;
    reg [1:0]  ch_q;
    reg [3:0]  wr_ptr_q;
    reg        half_q;
    reg [3:0]  seq_cnt_q;
    reg        use_b_q;
    reg [4:0]  scan_pos_q;
    reg        trig_prev_q;

    reg [9:0]  result_buffer [0:15];

    wire        tad_tick;
    wire [1:0]  last_ch;
    wire        trig_now;
    wire        conv_end;
    wire        group_end;
    wire [3:0]  scan_sel;
    wire        bus_req;
    wire        bus_wr;
    wire [15:0] wd;

    // 00 one channel, 01 two channels, 1x four channels
    function [1:0] last_chan;
        input [1:0] channel_count_sel;
        begin
            last_chan = channel_count_sel[1] ? 2'h3 : {1'b0, channel_count_sel[0]};
        end
    endfunction

    // lowest mask bit at or above pos, wrapping to the lowest set bit
    function [3:0] scan_pick;
        input [15:0] mask;
        input [4:0]  pos;
        integer      i;
        reg          hit;
        begin
            scan_pick = 4'h0;
            hit = 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                if (mask[i]) begin
                    if (i >= pos) begin
                        scan_pick = i[3:0];
                        hit = 1'b1;
                    end else if (!hit) begin
                        scan_pick = i[3:0];
                    end
                end
            end
            if (!hit) begin
                for (i = 15; i >= 0; i = i - 1) begin
                    if (mask[i]) begin
                        scan_pick = i[3:0];
                    end
                end
            end
        end
    endfunction

    function [15:0] fmt_word;
        input [9:0] d;
        input [1:0] f;
        begin
            case (f)
                2'h0: fmt_word = {6'h00, d};
                2'h1: fmt_word = {{6{~d[9]}}, ~d[9], d[8:0]};
                2'h2: fmt_word = {d, 6'h00};
                default: fmt_word = {~d[9], d[8:0], 6'h00};
            endcase
        end
    endfunction

    // byte-lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  sel;
        begin
            merge16 = {sel[1] ? nw[15:8] : old[15:8],
                       sel[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    assign bus_req = cyc_i && stb_i && !ack_o;
    assign bus_wr  = bus_req && we_i;
    assign wd      = dat_i[15:0];
    // converter clock period is (divider + 1) half instruction cycles
    assign tad_tick  = (state_q != S_IDLE) &&
                       (tad_cnt_q == conv_clock_divider_q);
    assign last_ch   = last_chan(channel_count_sel_q);
    assign trig_now  = (trigger_source_sel_q == `TRIG_EXT_INT) ? trig_i[0] :
                       (trigger_source_sel_q == `TRIG_TIMER)   ? trig_i[1] :
                       (trigger_source_sel_q == `TRIG_PWM)     ? trig_i[2] :
                       1'b0;
    assign conv_end  = (state_q == S_CONV) && tad_tick &&
                       (ph_q == `CONV_TADS - 5'h01) && converter_on_q;
    assign group_end = conv_end && (ch_q == last_ch);
    assign scan_sel  = scan_pick(scan_input_mask_q, scan_pos_q);

    // result store; a partial conversion never writes, so an abort
    // leaves the last completed result in place
    always @(posedge clk_i) begin
        if (conv_end) begin
            result_buffer[wr_ptr_q] <= adc_result_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            converter_on_q            <= 1'b0;
            output_format_sel_q       <= 2'h0;
            trigger_source_sel_q      <= 3'h0;
            simultaneous_sample_sel_q <= 1'b0;
            sample_ctrl_q             <= 1'b0;
            done_q                    <= 1'b0;
            ch0_scan_enable_q         <= 1'b0;
            channel_count_sel_q       <= 2'h0;
            seq_per_irq_q             <= 4'h0;
            buffer_split_mode_q       <= 1'b0;
            alternate_mux_sel_q       <= 1'b0;
            auto_sample_clocks_q      <= 5'h00;
            conv_clock_divider_q      <= 6'h00;
            ch0_a_q                   <= 4'h0;
            ch0_b_q                   <= 4'h0;
            scan_input_mask_q         <= `REG_RESET;
            conv_irq_flag_q           <= 1'b0;
            state_q                   <= S_IDLE;
            tad_cnt_q                 <= 6'h00;
            ph_q                      <= 5'h00;
            ch_q                      <= 2'h0;
            wr_ptr_q                  <= 4'h0;
            half_q                    <= 1'b0;
            seq_cnt_q                 <= 4'h0;
            use_b_q                   <= 1'b0;
            scan_pos_q                <= 5'h00;
            trig_prev_q               <= 1'b0;
        end else begin
            trig_prev_q <= trig_now;
            if (state_q == S_IDLE || tad_tick) begin
                tad_cnt_q <= 6'h00;
            end else begin
                tad_cnt_q <= tad_cnt_q + 6'h01;
            end
            if (tad_tick) begin
                ph_q <= ph_q + 5'h01;
            end

            // off always wins, even over an automatic start this cycle
            if (!converter_on_q) begin
                state_q       <= S_IDLE;
                sample_ctrl_q <= 1'b0;
                ph_q          <= 5'h00;
                if (state_q == S_CONV) begin
                    if (simultaneous_sample_sel_q) begin
                        ch_q <= 2'h0;
                    end else if (ch_q != last_ch) begin
                        ch_q <= ch_q + 2'h1;
                    end else begin
                        ch_q <= 2'h0;
                    end
                end
            end else begin
                case (state_q)
                    S_IDLE: begin
                        if (sample_ctrl_q) begin
                            state_q <= S_SAMPLE_CTRL;
                            ph_q    <= 5'h00;
                        end
                    end
                    S_SAMPLE_CTRL: begin
                        if (trigger_source_sel_q == `TRIG_AUTO) begin
                            if (tad_tick && ph_q + 5'h01 >=
                                auto_sample_clocks_q) begin
                                state_q <= S_CONV;
                                ph_q    <= 5'h00;
                            end
                        end else if (trigger_source_sel_q == `TRIG_SOFT) begin
                            if (!sample_ctrl_q) begin
                                state_q <= S_SYNC;
                                ph_q    <= 5'h00;
                            end
                        end else if (trig_now && !trig_prev_q) begin
                            sample_ctrl_q <= 1'b0;
                            state_q       <= S_SYNC;
                            ph_q          <= 5'h00;
                        end
                    end
                    S_SYNC: begin
                        if (tad_tick && ph_q == `SYNC_TADS - 5'h01) begin
                            state_q <= S_CONV;
                            ph_q    <= 5'h00;
                        end
                    end
                    S_CONV: begin
                        if (conv_end) begin
                            ph_q     <= 5'h00;
                            wr_ptr_q <= wr_ptr_q + 4'h1;
                            if (!group_end) begin
                                ch_q <= ch_q + 2'h1;
                                // held samples convert back to back
                                if (!simultaneous_sample_sel_q) begin
                                    state_q <= sample_ctrl_q ? S_SAMPLE_CTRL
                                                             : S_IDLE;
                                end
                            end else begin
                                ch_q    <= 2'h0;
                                state_q <= sample_ctrl_q ? S_SAMPLE_CTRL : S_IDLE;
                                use_b_q <= alternate_mux_sel_q &&
                                           !use_b_q;
                                scan_pos_q <= {1'b0, scan_sel} + 5'h01;
                                seq_cnt_q  <= seq_cnt_q + 4'h1;
                                if (seq_cnt_q == seq_per_irq_q) begin
                                    seq_cnt_q  <= 4'h0;
                                    done_q     <= 1'b1;
                                    scan_pos_q <= 5'h00;
                                    if (buffer_split_mode_q) begin
                                        half_q   <= !half_q;
                                        wr_ptr_q <= {!half_q, 3'h0};
                                    end else begin
                                        wr_ptr_q <= 4'h0;
                                    end
                                end
                            end
                        end
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end

            // software writes; configuration stays legal only while off
            if (bus_wr && sel_i[1:0] != 2'h0) begin
                case (adr_i)
                    `ADC_CTRL1_OFS: begin
                        if (sel_i[1]) begin
                            converter_on_q      <= wd[`CTRL1_ON_BIT];
                            output_format_sel_q <=
                                wd[`CTRL1_FMT_HI:`CTRL1_FMT_LO];
                        end
                        if (sel_i[0]) begin
                            trigger_source_sel_q <=
                                wd[`CTRL1_TRIG_HI:`CTRL1_TRIG_LO];
                            simultaneous_sample_sel_q <= wd[`CTRL1_SIM_BIT];
                            sample_ctrl_q <= wd[`CTRL1_SAMPLE_CTRL_BIT];
                            if (!wd[`CTRL1_DONE_BIT]) begin
                                done_q <= 1'b0;
                            end
                        end
                    end
                    `ADC_CTRL2_OFS: begin
                        if (sel_i[1]) begin
                            ch0_scan_enable_q   <= wd[`CTRL2_SCAN_BIT];
                            channel_count_sel_q <=
                                wd[`CTRL2_CHANNEL_COUNT_SEL_HI:`CTRL2_CHANNEL_COUNT_SEL_LO];
                        end
                        if (sel_i[0]) begin
                            seq_per_irq_q <=
                                wd[`CTRL2_SEQ_PER_IRQ_HI:`CTRL2_SEQ_PER_IRQ_LO];
                            buffer_split_mode_q <= wd[`CTRL2_SPLIT_BIT];
                            alternate_mux_sel_q <= wd[`CTRL2_ALT_BIT];
                        end
                    end
                    `ADC_CTRL3_OFS: begin
                        if (sel_i[1]) begin
                            auto_sample_clocks_q <=
                                wd[`CTRL3_AUTO_SAMPLE_CLOCKS_HI:`CTRL3_AUTO_SAMPLE_CLOCKS_LO];
                        end
                        if (sel_i[0]) begin
                            conv_clock_divider_q <=
                                wd[`CTRL3_DIV_HI:`CTRL3_DIV_LO];
                        end
                    end
                    `ADC_INSEL_OFS: begin
                        if (sel_i[0]) begin
                            ch0_a_q <= wd[3:0];
                            ch0_b_q <= wd[7:4];
                        end
                    end
                    `ADC_SCAN_OFS: begin
                        scan_input_mask_q <=
                            merge16(scan_input_mask_q, wd, sel_i[1:0]);
                    end
                    `ADC_STAT_OFS: begin
                        if (sel_i[0] && wd[`STAT_IRQ_BIT]) begin
                            conv_irq_flag_q <= 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // a new interrupt event outranks a clear in the same cycle
            if (group_end && seq_cnt_q == seq_per_irq_q) begin
                conv_irq_flag_q <= 1'b1;
                done_q          <= 1'b1;
            end
        end
    end

    // wishbone answer: ack one cycle after the strobe, dropped the next
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req;
            dat_o <= 32'h00000000;
            if (bus_req && !we_i) begin
                if (adr_i[7:6] == 2'h1 && adr_i[1:0] == 2'h0) begin
                    dat_o <= {16'h0000, fmt_word(result_buffer[adr_i[5:2]],
                                                 output_format_sel_q)};
                end else begin
                    case (adr_i)
                        `ADC_CTRL1_OFS: dat_o <= {16'h0000,
                            converter_on_q, 5'h00, output_format_sel_q,
                            trigger_source_sel_q, 1'b0,
                            simultaneous_sample_sel_q, 1'b0,
                            sample_ctrl_q, done_q};
                        `ADC_CTRL2_OFS: dat_o <= {16'h0000, 5'h00,
                            ch0_scan_enable_q, channel_count_sel_q, half_q,
                            1'b0, seq_per_irq_q, buffer_split_mode_q,
                            alternate_mux_sel_q};
                        `ADC_CTRL3_OFS: dat_o <= {16'h0000, 3'h0,
                            auto_sample_clocks_q, 2'h0, conv_clock_divider_q};
                        `ADC_INSEL_OFS: dat_o <= {24'h000000, ch0_b_q, ch0_a_q};
                        `ADC_SCAN_OFS:  dat_o <= {16'h0000, scan_input_mask_q};
                        `ADC_STAT_OFS:  dat_o <= {31'h00000000,
                                                  conv_irq_flag_q};
                        default:        dat_o <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // analog-side controls, registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            ch0_input_o   <= 4'h0;
            mux_b_o       <= 1'b0;
            sample_hold_o <= 4'h0;
            conv_busy_o   <= 1'b0;
            conv_chan_o   <= 2'h0;
            irq_o         <= 1'b0;
        end else begin
            mux_b_o <= use_b_q;
            if (ch0_scan_enable_q && !use_b_q) begin
                ch0_input_o <= scan_sel;
            end else begin
                ch0_input_o <= use_b_q ? ch0_b_q : ch0_a_q;
            end
            if (state_q == S_SAMPLE_CTRL || state_q == S_SYNC) begin
                if (simultaneous_sample_sel_q) begin
                    sample_hold_o <= channel_count_sel_q[1] ? 4'hF :
                                     channel_count_sel_q[0] ? 4'h3 :
                                     4'h1;
                end else begin
                    sample_hold_o <= 4'h1 << ch_q;
                end
            end else begin
                sample_hold_o <= 4'h0;
            end
            conv_busy_o <= (state_q == S_CONV) && converter_on_q;
            conv_chan_o <= ch_q;
            irq_o       <= conv_irq_flag_q;
        end
    end

endmodule // sar_adc_sequencer
`default_nettype wire

// ===== rtl/sar_adc_sequencer_regs.vh
// register offsets, field positions and timing counts of the converter sequencer
`ifndef SAR_ADC_SEQUENCER_REGS_VH
`define SAR_ADC_SEQUENCER_REGS_VH

`define ADC_CTRL1_OFS       8'h00
`define ADC_CTRL2_OFS       8'h04
`define ADC_CTRL3_OFS       8'h08
`define ADC_INSEL_OFS       8'h0C
`define ADC_SCAN_OFS        8'h10
`define ADC_STAT_OFS        8'h14
`define ADC_BUF_OFS         8'h40

`define CTRL1_ON_BIT        15
`define CTRL1_FMT_HI        9
`define CTRL1_FMT_LO        8
`define CTRL1_TRIG_HI       7
`define CTRL1_TRIG_LO       5
`define CTRL1_SIM_BIT       3
`define CTRL1_SAMPLE_CTRL_BIT      1
`define CTRL1_DONE_BIT      0

`define CTRL2_SCAN_BIT      10
`define CTRL2_CHANNEL_COUNT_SEL_HI       9
`define CTRL2_CHANNEL_COUNT_SEL_LO       8
`define CTRL2_HALF_BIT      7
`define CTRL2_SEQ_PER_IRQ_HI       5
`define CTRL2_SEQ_PER_IRQ_LO       2
`define CTRL2_SPLIT_BIT     1
`define CTRL2_ALT_BIT       0

`define CTRL3_AUTO_SAMPLE_CLOCKS_HI       12
`define CTRL3_AUTO_SAMPLE_CLOCKS_LO       8
`define CTRL3_DIV_HI        5
`define CTRL3_DIV_LO        0

`define STAT_IRQ_BIT        0

`define TRIG_SOFT           3'h0
`define TRIG_EXT_INT        3'h1
`define TRIG_TIMER          3'h2
`define TRIG_PWM            3'h3
`define TRIG_AUTO           3'h7

`define CONV_TADS           5'h0C
`define SYNC_TADS           5'h02
`define REG_RESET           16'h0000

`endif

// ===== testbench/sar_adc_sequencer_chk.sv
// port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [3:0]  sample_hold_o,
    input wire logic        conv_busy_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // an off write is the only legal way to cut a conversion short
    wire off_wr = cyc_i && stb_i && we_i && adr_i == 8'h00 && !dat_i[15];
    wire clr_wr = cyc_i && stb_i && we_i && adr_i == 8'h14 && dat_i[0];
    wire gap_rd = !we_i && adr_i >= 8'h18 && adr_i < 8'h40;
    sequence s_conv_run; conv_busy_o [*8]; endsequence
    sequence s_abort; ##[0:8] off_wr; endsequence
    property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    property p_upper_zero; ack_o && !we_i |-> dat_o[31:16] == 16'h0000;
    endproperty
    property p_gap_zero; ack_o && gap_rd |-> dat_o == 32'h0000_0000;
    endproperty
    property p_conv_len; $rose(conv_busy_o) |-> s_conv_run or s_abort;
    endproperty
    property p_hold_free; $rose(conv_busy_o) |=> sample_hold_o == 4'h0;
    endproperty
    property p_irq_sticky; $fell(irq_o) |->
        $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3); endproperty
    property p_irq_cause; $rose(irq_o) |-> $past(conv_busy_o, 2)
        || $past(conv_busy_o, 3) || $past(conv_busy_o, 4); endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read half not zero");
    a_gap_zero: assert property (p_gap_zero)
        else $error("unmapped read not zero");
    a_conv_len: assert property (p_conv_len)
        else $error("conversion too short");
    a_hold_free: assert property (p_hold_free)
        else $error("hold still tracking in conversion");
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("flag dropped without clear");
    a_irq_cause: assert property (p_irq_cause)
        else $error("flag not after a conversion");
endmodule // sar_adc_sequencer_chk
bind sar_adc_sequencer sar_adc_sequencer_chk u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sample_hold_o(sample_hold_o), .conv_busy_o(conv_busy_o), .irq_o(irq_o));
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, ack_o, mux_b_o, conv_busy_o, irq_o;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0, ch0_input_o, sample_hold_o;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [2:0]  trig_i = 3'h0;
    logic [9:0]  adc_result_i = 10'h155;
    logic [1:0]  conv_chan_o;
    logic [15:0] fmt [0:3] = '{16'h02A5, 16'h00A5, 16'hA940, 16'h2940};
    logic [39:0] rows [0:5] = '{40'h04_073D_073D, 40'h08_1F3F_1F3F,
        40'h0C_00FF_00FF, 40'h10_A5C3_A5C3, 40'h14_0001_0000, 40'h30_1234_0000};
    int          bad_count = 0, check_count = 0, n;
    time         t0;
    always #12.5 clk_i = ~clk_i;
    sar_adc_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .trig_i(trig_i),
        .adc_result_i(adc_result_i), .ch0_input_o(ch0_input_o),
        .mux_b_o(mux_b_o), .sample_hold_o(sample_hold_o),
        .conv_busy_o(conv_busy_o), .conv_chan_o(conv_chan_o), .irq_o(irq_o));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {16'h0000, d};
        sel_i <= 4'h3;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        chk({31'h0, ack_o}, 32'h1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    function automatic logic pick(input int k);
        return k == 0 ? conv_busy_o : k == 1 ? irq_o : sample_hold_o[0];
    endfunction
    // bounded so a stuck sequencer ends as a mismatch, not a hang
    task automatic wait_hi(input int k);
        n = 0;
        while (pick(k) !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, n < 1000}, 32'h1);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({conv_chan_o, ch0_input_o, mux_b_o, sample_hold_o, conv_busy_o,
             irq_o}, 0);
        foreach (rows[i]) begin
            bus(1'b1, rows[i][39:32], rows[i][31:16]);
            bus(1'b0, rows[i][39:32], 16'h0000);
            chk(rd, {16'h0000, rows[i][15:0]});
        end
        bus(1'b1, 8'h04, 16'h0004);
        bus(1'b1, 8'h08, 16'h0100);
        bus(1'b1, 8'h00, 16'h80E2);
        wait_hi(0);
        bus(1'b1, 8'h00, 16'h0000);
        repeat (2) @(posedge clk_i);
        chk({31'h0, conv_busy_o}, 32'h0);
        // the conversion was aborted before completing, so control register 1 reads back zero with done clear
        bus(1'b0, 8'h00, 16'h0000);
        chk(rd, 32'h0);
        adc_result_i <= 10'h2A5;
        bus(1'b1, 8'h00, 16'h80E2);
        wait_hi(2);
        t0 = $time;
        while (sample_hold_o[0] === 1'b1) @(posedge clk_i);
        wait_hi(2);
        chk((($time - t0) / 25), 32'd13);
        chk({27'h0, mux_b_o, ch0_input_o}, 32'hF);
        wait_hi(1);
        adc_result_i <= 10'h1C3;
        repeat (16) @(posedge clk_i);
        bus(1'b1, 8'h00, 16'h0000);
        bus(1'b0, 8'h40, 16'h0000);
        chk(rd, 32'h1C3);
        bus(1'b1, 8'h40, 16'h03FF);
        bus(1'b0, 8'h40, 16'h0000);
        chk(rd, 32'h1C3);
        bus(1'b0, 8'h44, 16'h0000);
        chk(rd, 32'h2A5);
        bus(1'b0, 8'h14, 16'h0000);
        chk(rd, 32'h1);
        bus(1'b1, 8'h14, 16'h0001);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, 8'h00, 16'(f) << 8);
            bus(1'b0, 8'h44, 16'h0000);
            chk(rd, {16'h0000, fmt[f]});
        end
        // software trigger: the new conversion overwrites entry 1 (the aborted run's slot) with 1C3
        bus(1'b1, 8'h00, 16'h8002);
        bus(1'b1, 8'h00, 16'h8000);
        wait_hi(1);
        bus(1'b0, 8'h44, 16'h0000);
        chk(rd, 32'h1C3);
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
